// ---- logic/hmc_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - 8-bit pointer, cleared at reset
// - pointer decodes registers and value RAM
// - start bit runs monitoring, zero is standby
// - clearing start leaves interrupt pins asserted
// - enable bit gates interrupt pin
// - polarity bit picks drive style
// - suppress bit releases interrupt and reset/overtemp pins, keeps status
// - suppress bit halts monitoring until cleared
// - reset request drives 10 ms low pulse when pin function is reset
// - reset request bit clears after pulse
// - chassis clear pulses latch pin, self-clears
// - bit six sets general output level
// - init bit reloads defaults, reads zero
// - configuration resets to suppress only
// - status bits 0-6 flag limit crossings
// - status bit 7 zero on chained low
// - status read returns then clears
// - mask bit keeps its status flag off the interrupt pin
module hmc_regs #(
  parameter int unsigned PULSE_CYCLES = hmc_pkg::PULSE_CYCLES,
  parameter logic [6:0]  BUS_ADDR     = hmc_pkg::BUS_ADDR_DEFAULT
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       int_in_n,
  input  wire logic       intrusion_latch_input,
  output logic            intrusion_out,
  output logic            intrusion_oe,
  output logic            irq_pin_out,
  output logic            irq_pin_oe,
  output logic            reset_or_overtemp_pin_out,
  output logic            reset_or_overtemp_pin_oe,
  output logic            general_output_pin,
  output logic            monitor_run,
  input  wire logic [6:0] limit_event,
  input  wire logic [3:0] status2_event,
  input  wire logic       overtemp_shutdown_signal
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       scl_d;
  logic       sda_d;
  logic       scl_s;
  logic       sda_s;
  logic       int_in_s;
  logic       ci_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 4'hf;
      sync_b <= 4'hf;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      sync_a <= {intrusion_latch_input, int_in_n, sda_in, scl_in};
      sync_b <= sync_a;
      scl_d  <= sync_b[0];
      sda_d  <= sync_b[1];
    end
  end

  assign scl_s    = sync_b[0];
  assign sda_s    = sync_b[1];
  assign int_in_s = sync_b[2];
  assign ci_s     = sync_b[3];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] pointer;
  logic [7:0] cfg;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic [7:0] fan;
  logic [7:0] oscfg;
  logic [7:0] value_ram [hmc_pkg::RAM_WORDS];
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // serial bus slave
  // ----------------------------------------------------------------
  hmc_pkg::hmc_bus_e bus_state;
  logic [7:0]        shreg;
  logic [2:0]        bit_cnt;
  logic              byte_full;
  logic              rd_dir;
  logic              first_byte;
  logic              master_nack;
  logic              sda_drive;
  logic              wr_ptr_stb;
  logic              wr_data_stb;
  logic              rd_stb;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_state   <= hmc_pkg::BUS_IDLE;
      shreg       <= 8'h00;
      bit_cnt     <= 3'h0;
      byte_full   <= 1'b0;
      rd_dir      <= 1'b0;
      first_byte  <= 1'b0;
      master_nack <= 1'b0;
      sda_drive   <= 1'b0;
      wr_ptr_stb  <= 1'b0;
      wr_data_stb <= 1'b0;
      rd_stb      <= 1'b0;
    end else begin
      wr_ptr_stb  <= 1'b0;
      wr_data_stb <= 1'b0;
      rd_stb      <= 1'b0;
      if (start_det) begin
        bus_state  <= hmc_pkg::BUS_ADDR;
        bit_cnt    <= 3'h0;
        byte_full  <= 1'b0;
        first_byte <= 1'b1;
        sda_drive  <= 1'b0;
      end else if (stop_det) begin
        bus_state <= hmc_pkg::BUS_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (bus_state)
          hmc_pkg::BUS_ADDR, hmc_pkg::BUS_WR: begin
            if (scl_rise && !byte_full) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                byte_full <= 1'b1;
              end
            end else if (scl_fall && byte_full) begin
              byte_full <= 1'b0;
              if (bus_state == hmc_pkg::BUS_ADDR) begin
                if (shreg[7:1] == BUS_ADDR) begin
                  sda_drive <= 1'b1;
                  rd_dir    <= shreg[0];
                  bus_state <= hmc_pkg::BUS_ADDR_AK;
                end else begin
                  bus_state <= hmc_pkg::BUS_IDLE;
                end
              end else begin
                sda_drive  <= 1'b1;
                bus_state  <= hmc_pkg::BUS_WR_AK;
                first_byte <= 1'b0;
                if (first_byte) begin
                  wr_ptr_stb <= 1'b1;
                end else begin
                  wr_data_stb <= 1'b1;
                end
              end
            end
          end
          hmc_pkg::BUS_ADDR_AK, hmc_pkg::BUS_WR_AK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (bus_state == hmc_pkg::BUS_ADDR_AK && rd_dir) begin
                // read side effect fires as the byte is loaded
                shreg     <= rd_mux;
                sda_drive <= !rd_mux[7];
                rd_stb    <= 1'b1;
                bus_state <= hmc_pkg::BUS_RD;
              end else begin
                sda_drive <= 1'b0;
                bus_state <= hmc_pkg::BUS_WR;
              end
            end
          end
          hmc_pkg::BUS_RD: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                sda_drive <= 1'b0;
                bus_state <= hmc_pkg::BUS_RD_AK;
              end else begin
                shreg     <= {shreg[6:0], 1'b0};
                sda_drive <= !shreg[6];
                bit_cnt   <= bit_cnt + 3'h1;
              end
            end
          end
          hmc_pkg::BUS_RD_AK: begin
            if (scl_rise) begin
              master_nack <= sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (master_nack) begin
                bus_state <= hmc_pkg::BUS_IDLE;
              end else begin
                shreg     <= rd_mux;
                sda_drive <= !rd_mux[7];
                rd_stb    <= 1'b1;
                bus_state <= hmc_pkg::BUS_RD;
              end
            end
          end
          default: begin
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_drive;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_cfg;
  logic wr_mask1;
  logic wr_mask2;
  logic wr_fan;
  logic wr_oscfg;
  logic wr_ram;
  logic rd_stat1;
  logic rd_stat2;
  logic in_ram;
  logic init_req;

  assign in_ram   = (pointer >= hmc_pkg::OFS_RAM_LO) && (pointer <= hmc_pkg::OFS_RAM_HI);
  assign wr_cfg   = wr_data_stb && (pointer == hmc_pkg::OFS_CFG);
  assign wr_mask1 = wr_data_stb && (pointer == hmc_pkg::OFS_MASK1);
  assign wr_mask2 = wr_data_stb && (pointer == hmc_pkg::OFS_MASK2);
  assign wr_fan   = wr_data_stb && (pointer == hmc_pkg::OFS_FAN);
  assign wr_oscfg = wr_data_stb && (pointer == hmc_pkg::OFS_OSCFG);
  assign wr_ram   = wr_data_stb && in_ram;
  assign rd_stat1 = rd_stb && (pointer == hmc_pkg::OFS_STAT1);
  assign rd_stat2 = rd_stb && (pointer == hmc_pkg::OFS_STAT2);
  assign init_req = wr_cfg && shreg[hmc_pkg::CFG_INIT];

  always_comb begin
    rd_mux = 8'h00;
    case (pointer)
      hmc_pkg::OFS_CFG:   rd_mux = cfg;
      hmc_pkg::OFS_STAT1: rd_mux = stat1;
      hmc_pkg::OFS_STAT2: rd_mux = stat2;
      hmc_pkg::OFS_MASK1: rd_mux = mask1;
      hmc_pkg::OFS_MASK2: rd_mux = mask2;
      hmc_pkg::OFS_FAN:   rd_mux = fan;
      hmc_pkg::OFS_OSCFG: rd_mux = oscfg;
      default: begin
        if (in_ram) begin
          rd_mux = value_ram[pointer[4:0]];
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pointer <= hmc_pkg::RST_PTR;
    end else if (wr_ptr_stb) begin
      pointer <= shreg;
    end
  end

  // ----------------------------------------------------------------
  // pulse timers
  // ----------------------------------------------------------------
  hmc_pulse_if rst_pls ();
  hmc_pulse_if ci_pls ();

  logic rst_fn_sel;
  logic os_fn_sel;

  assign rst_fn_sel  = fan[hmc_pkg::FAN_RST_FN] && !fan[hmc_pkg::FAN_OS_FN];
  assign os_fn_sel   = fan[hmc_pkg::FAN_OS_FN] && !fan[hmc_pkg::FAN_RST_FN];
  assign rst_pls.req = cfg[hmc_pkg::CFG_RST_REQ] && rst_fn_sel;
  assign ci_pls.req  = cfg[hmc_pkg::CFG_CI_CLR];

  hmc_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_rst_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pls      (rst_pls)
  );

  hmc_pulse_timer #(.CYCLES(PULSE_CYCLES)) u_ci_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pls      (ci_pls)
  );

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  logic [7:0] next_cfg;
  logic       rst_end;

  // without the reset function there is no pulse to wait for
  assign rst_end = rst_pls.done || (cfg[hmc_pkg::CFG_RST_REQ] && !rst_fn_sel);

  always_comb begin
    next_cfg = cfg;
    if (wr_cfg) begin
      next_cfg = shreg;
      next_cfg[hmc_pkg::CFG_INIT]    = 1'b0;
      next_cfg[hmc_pkg::CFG_RST_REQ] = shreg[hmc_pkg::CFG_RST_REQ] || cfg[hmc_pkg::CFG_RST_REQ];
      next_cfg[hmc_pkg::CFG_CI_CLR]  = shreg[hmc_pkg::CFG_CI_CLR] || cfg[hmc_pkg::CFG_CI_CLR];
    end
    // a fresh request in the completion cycle wins over the self-clear
    if (rst_end && !(wr_cfg && shreg[hmc_pkg::CFG_RST_REQ])) begin
      next_cfg[hmc_pkg::CFG_RST_REQ] = 1'b0;
    end
    if (ci_pls.done && !(wr_cfg && shreg[hmc_pkg::CFG_CI_CLR])) begin
      next_cfg[hmc_pkg::CFG_CI_CLR] = 1'b0;
    end
    if (init_req) begin
      next_cfg = hmc_pkg::RST_CFG;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= hmc_pkg::RST_CFG;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // masks and pin function
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask1 <= hmc_pkg::RST_MASK1;
      mask2 <= hmc_pkg::RST_MASK2;
      fan   <= hmc_pkg::RST_FAN;
      oscfg <= hmc_pkg::RST_OSCFG;
    end else if (init_req) begin
      mask1 <= hmc_pkg::RST_MASK1;
      mask2 <= hmc_pkg::RST_MASK2;
      fan   <= hmc_pkg::RST_FAN;
      oscfg <= hmc_pkg::RST_OSCFG;
    end else begin
      if (wr_mask1) mask1 <= shreg;
      if (wr_mask2) mask2 <= shreg;
      if (wr_fan) fan <= shreg;
      if (wr_oscfg) oscfg <= shreg;
    end
  end

  // value ram has no reset, limits are the host's to load
  always_ff @(posedge core_clk) begin
    if (wr_ram) begin
      value_ram[pointer[4:0]] <= shreg;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic       mon_on;
  logic [7:0] next_stat1;
  logic [7:0] next_stat2;

  assign mon_on      = cfg[hmc_pkg::CFG_START] && !cfg[hmc_pkg::CFG_IRQ_CLR];
  assign monitor_run = mon_on;

  // set beats the read clear; shreg still holds the byte handed out,
  // so a flag landing between load and clear is not lost
  always_comb begin
    next_stat1 = rd_stat1 ? (stat1 & ~shreg) : stat1;
    next_stat2 = rd_stat2 ? (stat2 & ~shreg) : stat2;
    if (mon_on) begin
      next_stat1[6:0] = next_stat1[6:0] | limit_event;
      next_stat1[hmc_pkg::STAT1_CHAIN] = int_in_s;
      next_stat2[3:0] = next_stat2[3:0] | status2_event;
      next_stat2[hmc_pkg::STAT2_CI] = next_stat2[hmc_pkg::STAT2_CI] | ci_s;
      next_stat2[hmc_pkg::STAT2_OS] = next_stat2[hmc_pkg::STAT2_OS] | overtemp_shutdown_signal;
    end
    next_stat2[7:6] = 2'b00;
    if (init_req) begin
      next_stat1 = hmc_pkg::RST_STAT1;
      next_stat2 = hmc_pkg::RST_STAT2;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat1 <= hmc_pkg::RST_STAT1;
      stat2 <= hmc_pkg::RST_STAT2;
    end else begin
      stat1 <= next_stat1;
      stat2 <= next_stat2;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic [13:0] irq_src;
  logic        irq_active;
  logic        rst_os_low;

  // chained input taken live so a cleared flag cannot raise it
  assign irq_src = {~int_in_s & ~mask1[7], stat1[6:0] & ~mask1[6:0], stat2[5:0] & ~mask2[5:0]};
  // start is not a term: standby keeps a pending pin asserted
  assign irq_active = cfg[hmc_pkg::CFG_IRQ_EN] && !cfg[hmc_pkg::CFG_IRQ_CLR] && (|irq_src);
  assign rst_os_low = !cfg[hmc_pkg::CFG_IRQ_CLR]
                      && ((rst_fn_sel && rst_pls.busy) || (os_fn_sel && overtemp_shutdown_signal));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_pin_out              <= 1'b0;
      irq_pin_oe               <= 1'b0;
      reset_or_overtemp_pin_oe <= 1'b0;
      intrusion_oe             <= 1'b0;
      general_output_pin       <= 1'b0;
    end else begin
      irq_pin_out              <= cfg[hmc_pkg::CFG_IRQ_POL];
      irq_pin_oe               <= irq_active;
      reset_or_overtemp_pin_oe <= rst_os_low;
      intrusion_oe             <= ci_pls.busy;
      general_output_pin       <= cfg[hmc_pkg::CFG_GPO];
    end
  end

  assign reset_or_overtemp_pin_out = 1'b0;
  assign intrusion_out             = 1'b0;

endmodule

// ---- shared/hmc_pkg.sv ----
package hmc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_STAT1  = 8'h01;
  localparam logic [7:0] OFS_STAT2  = 8'h02;
  localparam logic [7:0] OFS_MASK1  = 8'h03;
  localparam logic [7:0] OFS_MASK2  = 8'h04;
  localparam logic [7:0] OFS_FAN    = 8'h05;
  localparam logic [7:0] OFS_OSCFG  = 8'h06;
  localparam logic [7:0] OFS_RAM_LO = 8'h20;
  localparam logic [7:0] OFS_RAM_HI = 8'h3f;
  localparam int         RAM_WORDS  = 32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CFG   = 8'h08;
  localparam logic [7:0] RST_STAT1 = 8'h00;
  localparam logic [7:0] RST_STAT2 = 8'h00;
  localparam logic [7:0] RST_MASK1 = 8'h00;
  localparam logic [7:0] RST_MASK2 = 8'h00;
  localparam logic [7:0] RST_FAN   = 8'h14;
  localparam logic [7:0] RST_OSCFG = 8'h01;
  localparam logic [7:0] RST_PTR   = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_START   = 0;
  localparam int CFG_IRQ_EN  = 1;
  localparam int CFG_IRQ_POL = 2;
  localparam int CFG_IRQ_CLR = 3;
  localparam int CFG_RST_REQ = 4;
  localparam int CFG_CI_CLR  = 5;
  localparam int CFG_GPO     = 6;
  localparam int CFG_INIT    = 7;
  localparam int FAN_OS_FN   = 6;
  localparam int FAN_RST_FN  = 7;
  localparam int STAT1_CHAIN = 7;
  localparam int STAT2_CI    = 4;
  localparam int STAT2_OS    = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          PULSE_TIME_MS = 10;
  localparam int          CLK_FREQ_HZ   = 200_000_000;
  localparam int unsigned PULSE_CYCLES  = PULSE_TIME_MS * (CLK_FREQ_HZ / 1000);

  // bus address of this device, value is arbitrary
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2c;

  typedef enum logic [2:0] {
    BUS_IDLE    = 3'b000,
    BUS_ADDR    = 3'b001,
    BUS_ADDR_AK = 3'b010,
    BUS_WR      = 3'b011,
    BUS_WR_AK   = 3'b100,
    BUS_RD      = 3'b101,
    BUS_RD_AK   = 3'b110
  } hmc_bus_e;

endpackage

// ---- shared/hmc_pulse_if.sv ----
`timescale 1ns/1ps
interface hmc_pulse_if;
  logic req;
  logic busy;
  logic done;
  modport ctrl  (output req, input  busy, input  done);
  modport timer (input  req, output busy, output done);
endinterface

// ---- logic/hmc_pulse_timer.sv ----
`timescale 1ns/1ps
module hmc_pulse_timer #(
  parameter int unsigned CYCLES = hmc_pkg::PULSE_CYCLES
) (
  input wire logic   core_clk,
  input wire logic   rstn,
  hmc_pulse_if.timer pls
);

  logic [31:0] count;

  // ----------------------------------------------------------------
  // pulse counter
  // ----------------------------------------------------------------
  // dropping req aborts without done, so a soft init stops the pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pls.busy <= 1'b0;
      pls.done <= 1'b0;
      count    <= 32'h0000_0000;
    end else begin
      pls.done <= 1'b0;
      if (pls.busy) begin
        if (!pls.req) begin
          pls.busy <= 1'b0;
        end else if (count == 32'h0000_0000) begin
          pls.busy <= 1'b0;
          pls.done <= 1'b1;
        end else begin
          count <= count - 32'h0000_0001;
        end
      end else if (pls.req && !pls.done) begin
        // done guard: req is still high in the cycle done shows
        pls.busy <= 1'b1;
        count    <= CYCLES - 32'h0000_0001;
      end
    end
  end

endmodule

// ---- testbench/hmc_regs_chk.sv ----
`timescale 1ns/1ps
module hmc_regs_chk #(
  parameter int unsigned PULSE_CYCLES = hmc_pkg::PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic intrusion_out,
  input wire logic intrusion_oe,
  input wire logic irq_pin_oe,
  input wire logic reset_or_overtemp_pin_out,
  input wire logic reset_or_overtemp_pin_oe,
  input wire logic general_output_pin
);
  // ------------------------------
  // pulse widths
  // ------------------------------
  // counters, since repetition counts that large would stall the tools
  int unsigned rst_cnt;
  int unsigned ci_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt <= 0;
      ci_cnt  <= 0;
    end else begin
      rst_cnt <= reset_or_overtemp_pin_oe ? rst_cnt + 1 : 0;
      ci_cnt  <= intrusion_oe ? ci_cnt + 1 : 0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_rst_len;
    $fell(reset_or_overtemp_pin_oe) |-> rst_cnt == PULSE_CYCLES;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse width");
  property p_ci_len;
    $fell(intrusion_oe) |-> ci_cnt == PULSE_CYCLES;
  endproperty
  a_ci_len: assert property (p_ci_len) else $error("intrusion clear width");
  property p_rst_low;
    reset_or_overtemp_pin_oe |-> !reset_or_overtemp_pin_out;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset pin not low");
  property p_ci_low;
    intrusion_oe |-> !intrusion_out;
  endproperty
  a_ci_low: assert property (p_ci_low) else $error("intrusion pin not low");
  property p_sda_od;
    sda_oe |-> !sda_out;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("data line driven high");
  property p_ack_scl_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("data moved with clock high");
  property p_gpo_bus;
    $changed(general_output_pin) |-> !scl_in;
  endproperty
  a_gpo_bus: assert property (p_gpo_bus) else $error("output moved off a write");
  property p_reset_idle;
    $rose(rstn) |-> !irq_pin_oe && !general_output_pin && !reset_or_overtemp_pin_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active at reset");
  c_rst: cover property ($rose(reset_or_overtemp_pin_oe));
  c_ci: cover property ($rose(intrusion_oe));
  c_irq: cover property ($rose(irq_pin_oe));
endmodule

bind hmc_regs hmc_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_hmc_regs_chk (
  .core_clk, .rstn, .scl_in, .sda_out, .sda_oe, .intrusion_out, .intrusion_oe, .irq_pin_oe,
  .reset_or_overtemp_pin_out, .reset_or_overtemp_pin_oe, .general_output_pin);

// ---- testbench/hmc_host_model.sv ----
`timescale 1ns/1ps
// ------------------------------
// bus host, scl low 40 ns high 24 ns
// ------------------------------
module hmc_host_model #(
  parameter logic [6:0] ADDR = hmc_pkg::BUS_ADDR_DEFAULT
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #16 sda_low = ~b;
    #24 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
  endtask
  // host always releases the ninth bit: lets the device ack writes, ends reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic start();
    if (!scl) begin
      #16 sda_low = 1'b0;
      #24 scl = 1'b1;
    end
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask
  task automatic stop();
    #16 sda_low = 1'b1;
    #24 scl = 1'b1;
    #12 sda_low = 1'b0;
    #24;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v, output logic [2:0] ak);
    logic [7:0] rx;
    start();
    byte_io({a, 1'b0}, rx, ak[2]);
    byte_io(p, rx, ak[1]);
    byte_io(v, rx, ak[0]);
    stop();
  endtask
  task automatic rd(input logic setp, input logic [7:0] p, output logic [7:0] v, output logic [2:0] ak);
    logic [7:0] rx;
    ak = 3'b000;
    if (setp) begin
      start();
      byte_io({ADDR, 1'b0}, rx, ak[2]);
      byte_io(p, rx, ak[1]);
    end
    start();
    byte_io({ADDR, 1'b1}, rx, ak[0]);
    byte_io(8'hff, v, rx[0]);
    stop();
  endtask
endmodule

// ---- testbench/hmc_regs_tb.sv ----
`timescale 1ns/1ps
module hmc_regs_tb;
  localparam int unsigned PULSE = 1000;
  localparam logic [6:0]  ADR   = hmc_pkg::BUS_ADDR_DEFAULT;
  localparam logic [7:0]  CFG   = hmc_pkg::OFS_CFG;
  localparam logic [7:0]  ST1   = hmc_pkg::OFS_STAT1;
  localparam logic [7:0]  DEF [7] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01};
  logic        core_clk    = 1'b0;
  logic        rstn        = 1'b0;
  logic        int_in_n    = 1'b1;
  logic        which       = 1'b0;
  logic        ci_in       = 1'b0;
  logic [6:0]  limit_event = 7'h00;
  logic        scl, host_low, sda_out, sda_oe, intrusion_out, intrusion_oe, irq_pin_out, irq_pin_oe;
  logic        reset_or_overtemp_pin_out, reset_or_overtemp_pin_oe, general_output_pin, monitor_run;
  logic [2:0]  ak;
  logic [7:0]  d;
  int unsigned fails        = 0;
  int unsigned total_checks = 0;
  wire         sda      = ~(host_low | sda_oe);
  wire         pulse_oe = which ? intrusion_oe : reset_or_overtemp_pin_oe;
  always #2.5 core_clk = ~core_clk;
  hmc_host_model i_hmc_host_model (.scl(scl), .sda_low(host_low), .sda(sda));
  hmc_regs #(.PULSE_CYCLES(PULSE)) i_hmc_regs (
    .core_clk, .rstn, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .int_in_n,
    .intrusion_latch_input(ci_in), .intrusion_out, .intrusion_oe, .irq_pin_out, .irq_pin_oe,
    .reset_or_overtemp_pin_out, .reset_or_overtemp_pin_oe, .general_output_pin, .monitor_run,
    .limit_event, .status2_event(4'h0), .overtemp_shutdown_signal(1'b0));
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] v);
    i_hmc_host_model.wr(ADR, p, v, ak);
    chk("write ack", ak, 3'b000);
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] e);
    i_hmc_host_model.rd(1'b1, p, d, ak);
    chk("read ack", ak, 3'b000);
    chk("read data", d, e);
  endtask
  task automatic evt(input logic [6:0] v);
    @(posedge core_clk);
    #1 limit_event = v;
    @(posedge core_clk);
    #1 limit_event = 7'h00;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic all_defaults();
    for (int i = 0; i < 7; i++) begin
      rreg(i[7:0], DEF[i]);
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_map();
    logic [7:0] p [7] = '{8'h03, 8'h04, 8'h06, 8'h20, 8'h3f, 8'h07, 8'h01};
    logic [7:0] w [7] = '{8'h5a, 8'ha5, 8'h3c, 8'h96, 8'h69, 8'hff, 8'hff};
    for (int i = 0; i < 7; i++) begin
      wreg(p[i], w[i]);
      rreg(p[i], i < 5 ? w[i] : 8'h00);
    end
  endtask
  task automatic t_irq();
    wreg(CFG, 8'h03);
    chk("run", monitor_run, 1'b1);
    evt(7'h04);
    chk("irq drive", irq_pin_oe, 1'b1);
    chk("irq level", irq_pin_out, 1'b0);
    wreg(CFG, 8'h02);
    chk("standby", monitor_run, 1'b0);
    chk("irq held", irq_pin_oe, 1'b1);
    wreg(CFG, 8'h0b);
    chk("irq suppressed", irq_pin_oe, 1'b0);
    evt(7'h08);
    wreg(CFG, 8'h03);
    rreg(ST1, 8'h84);
    chk("irq after read", irq_pin_oe, 1'b0);
    rreg(ST1, 8'h80);
    int_in_n = 1'b0;
    evt(7'h00);
    chk("chained irq", irq_pin_oe, 1'b1);
    rreg(ST1, 8'h00);
    int_in_n = 1'b1;
    wreg(8'h03, 8'h04);
    evt(7'h04);
    chk("masked irq", irq_pin_oe, 1'b0);
    rreg(ST1, 8'h84);
    wreg(8'h03, 8'h00);
    wreg(CFG, 8'h47);
    evt(7'h01);
    chk("irq high drive", {irq_pin_oe, irq_pin_out}, 2'b11);
    chk("gpo", general_output_pin, 1'b1);
    wreg(CFG, 8'h45);
    chk("irq disabled", irq_pin_oe, 1'b0);
    rreg(ST1, 8'h81);
    ci_in = 1'b1;
    evt(7'h00);
    ci_in = 1'b0;
    rreg(8'h02, 8'h10);
    rreg(8'h02, 8'h00);
  endtask
  task automatic t_refuse();
    wreg(CFG, 8'h10);
    rreg(CFG, 8'h00);
    i_hmc_host_model.wr(ADR ^ 7'h01, CFG, 8'h40, ak);
    chk("foreign nack", ak[2], 1'b1);
    chk("gpo kept", general_output_pin, 1'b0);
    wreg(8'h05, 8'h80);
  endtask
  task automatic t_pulse(input logic [7:0] v);
    int unsigned n = 0;
    which = v[5];
    fork
      begin
        wreg(CFG, v);
        rreg(CFG, v);
      end
      begin
        for (int i = 0; i < 4000 && pulse_oe !== 1'b1; i++) begin
          @(posedge core_clk);
          #1;
        end
        while (pulse_oe === 1'b1 && n < 2 * PULSE) begin
          @(posedge core_clk);
          #1;
          n++;
        end
      end
    join
    chk("pulse cycles", n, PULSE);
    rreg(CFG, 8'h00);
  endtask
  initial begin
    #400us;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    i_hmc_host_model.rd(1'b0, 8'h00, d, ak);
    chk("pointer reset", d, 8'h08);
    all_defaults();
    t_map();
    wreg(8'h05, 8'h80);
    wreg(CFG, 8'h81);
    all_defaults();
    t_irq();
    t_refuse();
    t_pulse(8'h10);
    t_pulse(8'h20);
    end_of_test();
  end
endmodule
